// file: hdl/digital_io_port.sv
// Chosen here: the register addresses and the APB register port.
`include "digital_io_port_defines.svh"

module digital_io_port
  import digital_io_port_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [31:0] dio_i,
  output logic      [31:0] dio_o,
  output logic      [31:0] dio_oe,
  input  wire logic [31:0] seq_out,
  output logic      [31:0] seq_in,
  input  wire logic [31:0] link_rx,
  output logic      [31:0] link_tx,
  input  wire logic        readout_trig,
  input  wire logic [3:0]  seq_trig,
  input  wire logic [7:0]  trig_in,
  output logic             trig_stream_valid,
  output logic      [11:0] trig_stream_bits,
  input  wire logic        sample_rate_nominal,
  output logic             port_clk_ext,
  output logic             port_clk_slow,
  input  wire logic        iface_diff_stored,
  output logic             iface_diff,
  output logic             iface_diff_store
);

  logic [1:0]  rst_sync;
  logic        rst_n;

  logic [31:0] dio_meta;
  logic [31:0] dio_in;
  logic [7:0]  trig_meta;
  logic [7:0]  trig_pin;
  logic [1:0]  rate_meta;
  logic [1:0]  nv_meta;

  port_mode_e  mode;
  logic [3:0]  drive;
  logic [31:0] manual_out;
  logic [1:0]  int_status;
  logic [1:0]  int_mask;
  logic        trig_en;
  trig_src_e   trig_src;
  logic [11:0] trig_mask;
  logic [31:0] trig_hold;
  logic [1:0]  nv_load_cnt;

  logic        ovf_now;
  logic [7:0]  slot_cnt;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] next_dio_o;
  logic [1:0]  ev;

  trig_stream_if ts ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin and foreign-domain inputs pass two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dio_meta  <= 32'h0;
      dio_in    <= 32'h0;
      trig_meta <= 8'h00;
      trig_pin  <= 8'h00;
      rate_meta <= 2'b00;
      nv_meta   <= 2'b00;
    end else begin
      dio_meta  <= dio_i;
      dio_in    <= dio_meta;
      trig_meta <= trig_in;
      trig_pin  <= trig_meta;
      rate_meta <= {rate_meta[0], sample_rate_nominal};
      nv_meta   <= {nv_meta[0], iface_diff_stored};
    end
  end

  // APB: one wait state, so every answer comes from a flop
  assign addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_DRIVE) ||
                   (paddr == `REG_OUT) || (paddr == `REG_IN) ||
                   (paddr == `REG_STATUS) || (paddr == `REG_INT_STATUS) ||
                   (paddr == `REG_INT_MASK) || (paddr == `REG_TRIG_CTRL) ||
                   (paddr == `REG_TRIG_HOLD);
  assign wr_en = psel && penable && pready && pwrite && addr_ok;
  assign rd_en = psel && penable && !pready && !pwrite;

  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      `REG_CTRL: begin
        rd_mux[`CTRL_MODE_LSB +: 2] = mode;
        rd_mux[`CTRL_CLK_EXT]       = port_clk_ext;
        rd_mux[`CTRL_IFACE_DIFF]    = iface_diff;
      end
      `REG_DRIVE:      rd_mux[3:0] = drive;
      `REG_OUT:        rd_mux      = manual_out;
      `REG_IN:         rd_mux      = dio_in;
      `REG_STATUS: begin
        rd_mux[`STAT_OVF_NOW]    = ovf_now;
        rd_mux[`STAT_RATE_OK]    = rate_meta[1];
        rd_mux[`STAT_IFACE_DIFF] = iface_diff;
      end
      `REG_INT_STATUS: rd_mux[1:0] = int_status;
      `REG_INT_MASK:   rd_mux[1:0] = int_mask;
      `REG_TRIG_CTRL: begin
        rd_mux[`TRIG_EN]            = trig_en;
        rd_mux[`TRIG_SRC_LSB +: 2]  = trig_src;
        rd_mux[`TRIG_MASK_LSB +: 12] = trig_mask;
      end
      `REG_TRIG_HOLD:  rd_mux = trig_hold;
      default:         rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_en) begin
        prdata <= rd_mux;
      end
    end
  end

  // Mode and clock selection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode         <= MODE_MANUAL;
      port_clk_ext <= 1'b0;
    end else if (wr_en && paddr == `REG_CTRL) begin
      mode         <= port_mode_e'(pwdata[`CTRL_MODE_LSB +: 2]);
      port_clk_ext <= pwdata[`CTRL_CLK_EXT];
    end
  end

  // Codeword mode asks the clock generator for the slower port clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_clk_slow <= 1'b0;
    end else begin
      port_clk_slow <= (mode == MODE_CODEWORD);
    end
  end

  // Interface standard lives in non-volatile storage; reset reloads it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iface_diff       <= 1'b0;
      iface_diff_store <= 1'b0;
      nv_load_cnt      <= 2'h0;
    end else begin
      iface_diff_store <= 1'b0;
      if (nv_load_cnt != 2'h3) begin
        // Wait for the synchroniser to settle before loading
        nv_load_cnt <= nv_load_cnt + 2'h1;
        if (nv_load_cnt == 2'h2) begin
          iface_diff <= nv_meta[1];
        end
      end else if (wr_en && paddr == `REG_CTRL) begin
        iface_diff       <= pwdata[`CTRL_IFACE_DIFF];
        iface_diff_store <= 1'b1;
      end
    end
  end

  // Drive controls, one per 8-bit bus
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= `DRIVE_RST;
    end else if (wr_en && paddr == `REG_DRIVE) begin
      drive <= pwdata[3:0];
    end
  end

  // Manual values are kept even when the bus is not driven
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      manual_out <= `OUT_RST;
    end else if (wr_en && paddr == `REG_OUT && mode != MODE_SYNC) begin
      manual_out <= pwdata;
    end
  end

  always_comb begin
    case (mode)
      MODE_MANUAL:   next_dio_o = manual_out;
      MODE_SEQ:      next_dio_o = seq_out;
      MODE_CODEWORD: next_dio_o = seq_out;
      MODE_SYNC:     next_dio_o = link_rx;
      default:       next_dio_o = manual_out;
    endcase
  end

  // Value register always follows the source; enables gate the pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dio_o  <= 32'h0;
      dio_oe <= 32'h0;
    end else begin
      dio_o <= next_dio_o;
      for (int b = 0; b < 4; b++) begin
        dio_oe[b*8 +: 8] <= {8{drive[b]}};
      end
    end
  end

  // Sequencer and link feeds
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_in  <= 32'h0;
      link_tx <= 32'h0;
    end else begin
      case (mode)
        MODE_SEQ, MODE_CODEWORD: begin
          seq_in  <= dio_in;
          link_tx <= 32'h0;
        end
        MODE_SYNC: begin
          seq_in  <= link_rx;
          link_tx <= dio_in;
        end
        default: begin
          seq_in  <= 32'h0;
          link_tx <= 32'h0;
        end
      endcase
    end
  end

  // Each readout result occupies the port for one slot; a new
  // readout inside the slot cannot be carried and is an overflow
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= 8'h0;
      ovf_now  <= 1'b0;
    end else begin
      if (readout_trig) begin
        slot_cnt <= 8'(`RESULT_SLOT_CYC);
        if (slot_cnt != 8'h0) begin
          ovf_now <= 1'b1;
        end
      end else if (slot_cnt != 8'h0) begin
        slot_cnt <= slot_cnt - 8'h1;
      end else begin
        ovf_now <= 1'b0;
      end
    end
  end

  assign ev[`INT_OVF]  = ovf_now;
  assign ev[`INT_TRIG] = ts.fire;

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= 2'h0;
    end else begin
      if (wr_en && paddr == `REG_INT_STATUS) begin
        int_status <= (int_status & ~pwdata[1:0]) | ev;
      end else begin
        int_status <= int_status | ev;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= `INT_MASK_RST;
    end else if (wr_en && paddr == `REG_INT_MASK) begin
      int_mask <= pwdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  // Trigger stream configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_en   <= 1'b0;
      trig_src  <= SRC_INPUTS;
      trig_mask <= `MASK_RST;
      trig_hold <= `HOLD_RST;
    end else if (wr_en) begin
      if (paddr == `REG_TRIG_CTRL) begin
        trig_en   <= pwdata[`TRIG_EN];
        trig_src  <= trig_src_e'(pwdata[`TRIG_SRC_LSB +: 2]);
        trig_mask <= pwdata[`TRIG_MASK_LSB +: 12];
      end
      if (paddr == `REG_TRIG_HOLD) begin
        trig_hold <= pwdata;
      end
    end
  end

  assign ts.enable  = trig_en;
  assign ts.src     = trig_src;
  assign ts.mask    = trig_mask;
  assign ts.holdoff = trig_hold;
  assign ts.sources = {seq_trig, trig_pin};

  trig_stream_unit u_trig (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .t        (ts.unit)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_stream_valid <= 1'b0;
      trig_stream_bits  <= 12'h000;
    end else begin
      trig_stream_valid <= ts.fire;
      if (ts.fire) begin
        trig_stream_bits <= ts.fired_bits;
      end
    end
  end

endmodule

// file: hdl/digital_io_port_defines.svh
`ifndef DIGITAL_IO_PORT_DEFINES_SVH
`define DIGITAL_IO_PORT_DEFINES_SVH

`define REG_CTRL        12'h000
`define REG_DRIVE       12'h004
`define REG_OUT         12'h008
`define REG_IN          12'h00c
`define REG_STATUS      12'h010
`define REG_INT_STATUS  12'h014
`define REG_INT_MASK    12'h018
`define REG_TRIG_CTRL   12'h01c
`define REG_TRIG_HOLD   12'h020

`define CTRL_MODE_LSB   0
`define CTRL_CLK_EXT    4
`define CTRL_IFACE_DIFF 8
`define STAT_OVF_NOW    0
`define STAT_RATE_OK    1
`define STAT_IFACE_DIFF 2
`define INT_OVF         0
`define INT_TRIG        1
`define TRIG_EN         0
`define TRIG_SRC_LSB    1
`define TRIG_MASK_LSB   16

`define DRIVE_RST       4'h0
`define OUT_RST         32'h0000_0000
`define MASK_RST        12'h000
`define HOLD_RST        32'h0000_0000
`define INT_MASK_RST    2'h0

`define CLK_PERIOD_PS   25000
`define RESULT_SLOT_NS  200
`define RESULT_SLOT_CYC ((`RESULT_SLOT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SEQ_IF_MHZ      150
`define CODEWORD_IF_MHZ 50
`define NOMINAL_MSA     2400

`endif

// file: hdl/digital_io_port_pkg.sv
package digital_io_port_pkg;
  typedef enum logic [1:0] {
    MODE_MANUAL   = 2'h0,
    MODE_SEQ      = 2'h1,
    MODE_CODEWORD = 2'h2,
    MODE_SYNC     = 2'h3
  } port_mode_e;
  typedef enum logic [1:0] {
    SRC_INPUTS = 2'h0,
    SRC_SEQ    = 2'h1,
    SRC_MASK   = 2'h2,
    SRC_ALL    = 2'h3
  } trig_src_e;
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b01,
    HOLD_WAIT = 2'b10
  } hold_state_e;
endpackage

// file: hdl/trig_stream_if.sv
interface trig_stream_if;
  import digital_io_port_pkg::*;
  logic        enable;
  trig_src_e   src;
  logic [11:0] mask;
  logic [31:0] holdoff;
  logic [11:0] sources;
  logic        fire;
  logic [11:0] fired_bits;
  modport ctrl (output enable, src, mask, holdoff, sources, input fire, fired_bits);
  modport unit (input enable, src, mask, holdoff, sources, output fire, fired_bits);
endinterface

// file: hdl/trig_stream_unit.sv
module trig_stream_unit
  import digital_io_port_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  trig_stream_if.unit t
);
  hold_state_e state;
  logic [31:0] hold_cnt;
  logic [11:0] select;
  logic [11:0] hits;

  always_comb begin
    case (t.src)
      SRC_INPUTS: select = 12'h0ff;
      SRC_SEQ:    select = 12'hf00;
      SRC_MASK:   select = t.mask;
      default:    select = 12'hfff;
    endcase
  end

  // Low byte are input triggers, high nibble sequencer triggers
  assign hits = t.sources & select;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= HOLD_IDLE;
      hold_cnt   <= 32'h0;
      t.fire     <= 1'b0;
      t.fired_bits <= 12'h000;
    end else begin
      t.fire <= 1'b0;
      case (state)
        HOLD_IDLE: begin
          if (t.enable && |hits) begin
            t.fire       <= 1'b1;
            t.fired_bits <= hits;
            hold_cnt     <= t.holdoff;
            if (t.holdoff != 32'h0) begin
              state <= HOLD_WAIT;
            end
          end
        end
        HOLD_WAIT: begin
          // Triggers inside the holdoff are dropped, not queued
          if (!t.enable || hold_cnt <= 32'h1) begin
            state <= HOLD_IDLE;
          end
          hold_cnt <= hold_cnt - 32'h1;
        end
        default: state <= HOLD_IDLE;
      endcase
    end
  end
endmodule

// file: tb/digital_io_port_checker.sv
module digital_io_port_checker (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] dio_oe,
  input wire logic        trig_stream_valid,
  input wire logic [11:0] trig_stream_bits,
  input wire logic        port_clk_ext,
  input wire logic        port_clk_slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] oe_x;
  logic        wr;
  assign oe_x = {{8{dio_oe[24]}}, {8{dio_oe[16]}}, {8{dio_oe[8]}}, {8{dio_oe[0]}}};
  assign wr = psel && penable && pready && pwrite;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  AST_OE_BYTES: assert property (dio_oe == oe_x)
    else $error("drive split inside a byte");
  AST_OE_RESET: assert property ($rose(resetn) |-> dio_oe == 32'h0)
    else $error("bus driven out of reset");
  AST_OE_CAUSE: assert property ($changed(dio_oe) |-> $past(wr && paddr == 12'h004, 2))
    else $error("drive changed without a write");
  AST_WAIT_STATE: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access not two cycles");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  AST_BITS_HOLD: assert property (!trig_stream_valid |-> $stable(trig_stream_bits))
    else $error("trigger bits moved without pulse");
  AST_BITS_SET: assert property (trig_stream_valid |-> trig_stream_bits != 12'h000)
    else $error("trigger pulse with no source");
  AST_CLK_SET: assert property (wr && paddr == 12'h000 |=>
    port_clk_ext == $past(pwdata[4]) ##1
    port_clk_slow == ($past(pwdata[1:0], 2) == 2'h2))
    else $error("port clock request wrong");
  cover property (pslverr);
  cover property (trig_stream_valid);
  cover property ($rose(port_clk_slow));
endmodule

bind digital_io_port digital_io_port_checker digital_io_port_checker_inst (.*);

// file: tb/port_far_end.sv
module port_far_end (
  input  wire logic [31:0] dio_o,
  input  wire logic [31:0] dio_oe,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] dio_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven bytes carry the far instrument's own levels
  assign dio_i = (dio_o & dio_oe) | (ext_val & ~dio_oe);
endmodule

// file: tb/digital_io_port_tb.sv
module digital_io_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic        readout_trig, trig_stream_valid, port_clk_ext, port_clk_slow;
  logic        iface_diff, iface_diff_store;
  logic        sample_rate_nominal, iface_diff_stored;
  logic [3:0]  seq_trig, dv;
  logic [7:0]  trig_in;
  logic [11:0] paddr, trig_stream_bits;
  logic [31:0] pwdata, prdata, dio_i, dio_o, dio_oe, seq_out, seq_in, link_rx, link_tx;
  logic [31:0] ext_val, rd, v, m;
  integer      seed;
  int          error_cnt, tests_run, cyc, n, stores;

  digital_io_port digital_io_port_inst (.*);
  port_far_end port_far_end_inst (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // Non-volatile store beside the port: keeps what software last chose
  always @(posedge core_clk) begin
    if (iface_diff_store === 1'b1) begin
      iface_diff_stored <= iface_diff;
      stores++;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] x, logic [31:0] y);
    tests_run++;
    if (y !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, x, y);
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait if pready never rises
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdc(string nm, logic [11:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, e);
    chk(nm, x, rd);
  endtask

  task automatic count(int len);
    n = 0;
    repeat (len) begin
      @(posedge core_clk);
      n += int'(trig_stream_valid === 1'b1);
    end
  endtask

  function automatic logic [31:0] oe_of(logic [3:0] d);
    return {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
  endfunction

  function automatic logic [31:0] pins(logic [31:0] o);
    return (o & oe_of(dv)) | (ext_val & ~oe_of(dv));
  endfunction

  function automatic logic [11:0] sel(int s);
    return s == 0 ? 12'h0ff : s == 1 ? 12'hf00 : s == 2 ? 12'h102 : 12'hfff;
  endfunction

  initial begin
    {psel, penable, pwrite, readout_trig, seq_trig, trig_in, resetn} = '0;
    {paddr, pwdata, seq_out, link_rx, ext_val, dv} = '0;
    {sample_rate_nominal, iface_diff_stored} = 2'b11;
    seed = 32'h6ab3;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("dio_oe", 32'h0, dio_oe);
    chk("iface_diff", 32'h1, 32'(iface_diff));
    rdc("drive", 12'h004, 32'h0);
    rdc("status", 12'h010, 32'h6);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      dv = 4'($random(seed));
      ext_val <= $random(seed);
      wr(12'h008, v);
      wr(12'h004, 32'(dv));
      repeat (5) @(posedge core_clk);
      chk("dio_o", v, dio_o);
      chk("dio_oe", oe_of(dv), dio_oe);
      rdc("in", 12'h00c, pins(v));
    end
    $display("test manual done");
    dv = 4'h5;
    wr(12'h004, 32'(dv));
    seq_out <= $random(seed);
    link_rx <= $random(seed);
    for (int md = 0; md < 4; md++) begin
      v = $random(seed);
      wr(12'h000, {27'h0, md[0], 2'h0, md[1:0]});
      wr(12'h008, v);
      if (md != 3)
        m = v;
      repeat (5) @(posedge core_clk);
      v = md == 0 ? m : md == 3 ? link_rx : seq_out;
      chk("dio_o", v, dio_o);
      chk("seq_in", md == 0 ? 0 : md == 3 ? link_rx : pins(v), seq_in);
      chk("link_tx", md == 3 ? pins(v) : 0, link_tx);
      chk("clk", {md == 2, md[0]}, {port_clk_slow, port_clk_ext});
    end
    wr(12'h000, 32'h100);
    repeat (5) @(posedge core_clk);
    chk("out_kept", m, dio_o);
    chk("stores", 32'd5, 32'(stores));
    chk("iface_diff", 32'h1, 32'(iface_diff));
    apb(1'b0, 12'h0f0, 32'h0, rd, e);
    chk("slverr", 32'h1, 32'(e));
    $display("test modes done");
    wr(12'h018, 32'h1);
    repeat (3) begin
      readout_trig <= 1'b1;
      @(posedge core_clk);
      readout_trig <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    rdc("ovf_now", 12'h010, 32'h7);
    repeat (20) @(posedge core_clk);
    rdc("status", 12'h010, 32'h6);
    rdc("int_st", 12'h014, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    wr(12'h018, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("irq_mask", 32'h0, 32'(irq));
    wr(12'h014, 32'h1);
    rdc("int_st", 12'h014, 32'h0);
    $display("test overflow done");
    for (int s = 0; s < 4; s++) begin
      seq_trig <= 4'h0;
      trig_in <= 8'h00;
      repeat (6) @(posedge core_clk);
      wr(12'h01c, {4'h0, 12'h102, 13'h0, s[1:0], 1'b1});
      // Pins pass two sync flops; raise them first so all sources meet
      trig_in <= 8'h03;
      repeat (2) @(posedge core_clk);
      seq_trig <= 4'h1;
      for (int k = 0; k < 20 && trig_stream_valid !== 1'b1; k++)
        @(posedge core_clk);
      chk("trig_fire", 32'h1, 32'(trig_stream_valid));
      chk("trig_bits", 32'(sel(s) & 12'h103), 32'(trig_stream_bits));
    end
    // Quiet start, so the first fire opens the holdoff window
    seq_trig <= 4'h0;
    trig_in <= 8'h00;
    wr(12'h020, 32'd10);
    repeat (4) @(posedge core_clk);
    seq_trig <= 4'h1;
    count(30);
    chk("holdoff", 32'd3, 32'(n));
    rdc("int_st", 12'h014, 32'h2);
    wr(12'h01c, 32'h0);
    repeat (4) @(posedge core_clk);
    count(20);
    chk("disabled", 32'h0, 32'(n));
    $display("test trigger done");
    sample_rate_nominal <= 1'b0;
    resetn <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("dio_oe", 32'h0, dio_oe);
    chk("iface_diff", 32'h1, 32'(iface_diff));
    rdc("drive", 12'h004, 32'h0);
    rdc("status", 12'h010, 32'h4);
    $display("test reboot done");
    wrap_up();
  end
endmodule
